// File: core/ctx_regs.sv
// Per-context binding and resume-address register bank
`timescale 1ns/1ps
`default_nettype none
module ctx_regs
    import ctx_regs_pkg::*;
#(
    parameter int unsigned NUM_CTX = 4,
    parameter logic [NUM_CTX*ELEM_W-1:0] ELEM_PRESET = '0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cop_req_s cop_req,
    input wire logic binding_config_enable,
    input wire logic [NUM_CTX-1:0] bus_err_ctx,
    input wire logic [NUM_CTX-1:0] halted,
    input wire ctx_pipe_s [NUM_CTX-1:0] pipe,
    output logic [DATA_W-1:0] rdata,
    output logic rvalid,
    output logic [NUM_CTX-1:0] delay_slot_stop_flag,
    output logic [NUM_CTX-1:0] sc_fail,
    output logic [NUM_CTX*ELEM_W-1:0] owning_element_field
);
    // The index field is eight bits wide, so more contexts cannot be named
    if (NUM_CTX < 1 || NUM_CTX > NUM_CTX_MAX) begin : g_bad_num_ctx
        $error("NUM_CTX out of range");
    end

    typedef struct packed {
        logic [NUM_CTX-1:0] bus_err;
        logic [NUM_CTX-1:0][ELEM_W-1:0] elem;
        logic [NUM_CTX-1:0][DATA_W-1:0] resume;
        logic [NUM_CTX-1:0] ds_stop;
        logic [NUM_CTX-1:0] link;
        logic [NUM_CTX-1:0] link_broken;
        logic [NUM_CTX-1:0] sc_fail;
        logic [NUM_CTX-1:0] was_halted;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic [NUM_CTX-1:0] elem_preset_done;
    } state_s;

    state_s st;
    state_s next_st;
    read_src_e rsrc;

    // Per-context decode of the move port and of pipeline events
    logic [NUM_CTX-1:0] ctx_hit;
    logic [NUM_CTX-1:0] wr_binding;
    logic [NUM_CTX-1:0] wr_resume;
    logic [NUM_CTX-1:0] halt_edge;
    logic [NUM_CTX-1:0] retire_adv;

    for (genvar g = 0; g < NUM_CTX; g++) begin : g_ctx
        // Indices beyond the bank never match, so such writes are dropped and reads return zero
        assign ctx_hit[g] = (cop_req.ctx == 8'(g));
        assign wr_binding[g] = cop_req.wr && ctx_hit[g]
            && (cop_req.sel == SEL_BINDING);
        assign wr_resume[g] = cop_req.wr && ctx_hit[g]
            && (cop_req.sel == SEL_RESUME);
        // Only the first halted cycle captures, later retires are ignored
        assign halt_edge[g] = pipe[g].halt_req && !st.was_halted[g];
        // A branch keeps its own address when its delay slot retires
        assign retire_adv[g] = !halted[g] && pipe[g].retire
            && !pipe[g].in_delay_slot;
    end

    // Built from an empty word so reserved and scale bits cannot leak
    function automatic logic [DATA_W-1:0] binding_word(
        input logic [CTX_IDX_W-1:0] idx,
        input logic be,
        input logic [ELEM_W-1:0] el
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[CTX_IDX_LSB +: CTX_IDX_W] = idx;
        w[SCALE_ZERO_LSB +: SCALE_ZERO_W] = '0;
        w[BUS_ERR_BIT] = be;
        w[ELEM_LSB +: ELEM_W] = el;
        return w;
    endfunction : binding_word

    always_comb begin
        logic hit;
        logic [DATA_W-1:0] word;
        next_st = st;
        hit = 1'b0;
        word = '0;
        rsrc = RD_NONE;
        next_st.rvalid = cop_req.rd;
        next_st.sc_fail = '0;
        for (int i = 0; i < NUM_CTX; i++) begin
            hit = ctx_hit[i];
            // Preset elements load once after reset, not under reset
            if (!st.elem_preset_done[i]) begin
                next_st.elem[i] = (i == 0) ? ELEM_RESET_CTX0
                    : ELEM_PRESET[i*ELEM_W +: ELEM_W];
                next_st.elem_preset_done[i] = 1'b1;
            end
            if (wr_binding[i]) begin
                next_st.bus_err[i] = cop_req.wdata[BUS_ERR_BIT];
                if (binding_config_enable) begin
                    next_st.elem[i] =
                        cop_req.wdata[ELEM_LSB +: ELEM_W];
                end
            end
            // Set beats a same-cycle software clear; it is assigned after the write
            if (bus_err_ctx[i]) begin
                next_st.bus_err[i] = 1'b1;
            end
            if (retire_adv[i]) begin
                next_st.resume[i] = pipe[i].retire_pc;
            end
            if (halt_edge[i]) begin
                if (pipe[i].in_delay_slot) begin
                    next_st.resume[i] = pipe[i].branch_pc;
                    next_st.ds_stop[i] = 1'b1;
                end else begin
                    next_st.resume[i] = pipe[i].next_pc;
                    next_st.ds_stop[i] = 1'b0;
                end
            end
            next_st.was_halted[i] = halted[i];
            if (pipe[i].ll_exec) begin
                next_st.link[i] = 1'b1;
                next_st.link_broken[i] = 1'b0;
            end
            if (wr_resume[i]) begin
                next_st.resume[i] = cop_req.wdata;
                next_st.ds_stop[i] = 1'b0;
                if (st.link[i] || pipe[i].ll_exec) begin
                    next_st.link_broken[i] = 1'b1;
                end
            end
            if (pipe[i].sc_exec) begin
                next_st.sc_fail[i] = st.link_broken[i] || !st.link[i];
                next_st.link[i] = 1'b0;
                next_st.link_broken[i] = 1'b0;
            end
            if (cop_req.rd && hit) begin
                if (cop_req.sel == SEL_BINDING) begin
                    rsrc = RD_BINDING;
                    word = binding_word(8'(i), st.bus_err[i],
                        st.elem[i]);
                end else if (cop_req.sel == SEL_RESUME) begin
                    rsrc = RD_RESUME;
                    // Running contexts expose the last address retired outside a delay slot
                    word = st.resume[i];
                end
            end
        end
        unique case (rsrc)
            RD_BINDING, RD_RESUME: next_st.rdata = word;
            RD_NONE: next_st.rdata = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CTX; i++) begin
            owning_element_field[i*ELEM_W +: ELEM_W] = st.elem[i];
        end
    end
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign delay_slot_stop_flag = st.ds_stop;
    assign sc_fail = st.sc_fail;
endmodule : ctx_regs
`default_nettype wire

// File: pkg/ctx_regs_pkg.sv
// Shared constants and carriers for the per-context bind/restart registers
package ctx_regs_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_CTX_MAX = 256;
    localparam int unsigned CTX_IDX_LSB = 21;
    localparam int unsigned CTX_IDX_W = 8;
    localparam int unsigned SCALE_ZERO_LSB = 18;
    localparam int unsigned SCALE_ZERO_W = 3;
    localparam int unsigned BUS_ERR_BIT = 17;
    localparam int unsigned ELEM_LSB = 0;
    localparam int unsigned ELEM_W = 4;
    localparam logic BUS_ERR_RESET = 1'h0;
    localparam logic [ELEM_W-1:0] ELEM_RESET_CTX0 = 4'h0;
    localparam logic DS_STOP_RESET = 1'h0;
    localparam logic LINK_RESET = 1'h0;

    // Register select codes on the coprocessor move port
    localparam logic [1:0] SEL_BINDING = 2'h0;
    localparam logic [1:0] SEL_RESUME = 2'h1;

    typedef enum logic [1:0] {
        RD_BINDING,
        RD_RESUME,
        RD_NONE
    } read_src_e;

    // Coprocessor move request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] sel;
        logic [7:0] ctx;
        logic [DATA_W-1:0] wdata;
    } cop_req_s;

    // Pipeline view of one context
    typedef struct packed {
        logic halt_req;
        logic in_delay_slot;
        logic [DATA_W-1:0] branch_pc;
        logic [DATA_W-1:0] next_pc;
        logic [DATA_W-1:0] retire_pc;
        logic retire;
        logic ll_exec;
        logic sc_exec;
    } ctx_pipe_s;
endpackage : ctx_regs_pkg

// File: verif/ctx_regs_checker.sv
// Port-level assertions for the context register bank
`timescale 1ns/1ps
`default_nettype none
module ctx_regs_checker
    import ctx_regs_pkg::*;
#(parameter int unsigned NUM_CTX = 4) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cop_req_s cop_req,
    input wire logic binding_config_enable,
    input wire logic [NUM_CTX-1:0] bus_err_ctx,
    input wire logic [NUM_CTX-1:0] halted,
    input wire ctx_pipe_s [NUM_CTX-1:0] pipe,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic [NUM_CTX-1:0] delay_slot_stop_flag,
    input wire logic [NUM_CTX-1:0] sc_fail,
    input wire logic [NUM_CTX*ELEM_W-1:0] owning_element_field
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire logic rb = cop_req.rd && !cop_req.wr && cop_req.sel == SEL_BINDING
        && cop_req.ctx < NUM_CTX;
    wire logic r0 = rb && cop_req.ctx == 8'h00;
    wire logic w0 = cop_req.wr && cop_req.sel == SEL_RESUME && !cop_req.ctx;
    property p_idx; rb |=> rvalid && rdata[28:21] == $past(cop_req.ctx);
    endproperty
    a_idx: assert property (p_idx) else $error("index field");
    property p_scl; rb |=> rdata[20:18] == 3'h0; endproperty
    a_scl: assert property (p_scl) else $error("scale bits");
    property p_rsv; rb |=> !rdata[31:29] && !rdata[16:4]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_be; bus_err_ctx[0] ##1 r0 |=> rdata[17]; endproperty
    a_be: assert property (p_be) else $error("bus error flag");
    property p_el; r0 |=> rdata[3:0] == $past(owning_element_field[3:0]);
    endproperty
    a_el: assert property (p_el) else $error("element field");
    // First edge after release loads the preset, so it is skipped
    property p_hold; $past(resetn) && !binding_config_enable
        |=> $stable(owning_element_field); endproperty
    a_hold: assert property (p_hold) else $error("element write");
    property p_ds; w0 |=> !delay_slot_stop_flag[0]; endproperty
    a_ds: assert property (p_ds) else $error("stop flag");
    property p_sc; w0 ##1 (pipe[0].sc_exec && !pipe[0].ll_exec)
        |=> sc_fail[0]; endproperty
    a_sc: assert property (p_sc) else $error("store pass");
endmodule : ctx_regs_checker
bind ctx_regs ctx_regs_checker #(.NUM_CTX(NUM_CTX)) u_chk (.mclk(mclk),
    .resetn(resetn), .cop_req(cop_req), .bus_err_ctx(bus_err_ctx),
    .binding_config_enable(binding_config_enable), .halted(halted),
    .pipe(pipe), .rdata(rdata), .rvalid(rvalid), .sc_fail(sc_fail),
    .delay_slot_stop_flag(delay_slot_stop_flag),
    .owning_element_field(owning_element_field));
`default_nettype wire

// File: verif/ctx_regs_test.sv
// Self-checking bench for the context register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module ctx_regs_test import ctx_regs_pkg::*;;
    typedef struct packed {
        logic w, en; logic [1:0] s; logic [7:0] c; logic [31:0] d, e;
    } row_s;
    localparam row_s ROWS [5] = '{
        '{1'h0, 1'h0, SEL_BINDING, 8'h03, 32'h0, 32'h0060_0001},
        '{1'h1, 1'h0, SEL_BINDING, 8'h01, 32'h0002_0000, 32'h0022_0003},
        '{1'h1, 1'h1, SEL_BINDING, 8'h02, 32'h9, 32'h0040_0009},
        '{1'h1, 1'h0, SEL_RESUME, 8'h01, 32'h1234, 32'h1234},
        '{1'h1, 1'h0, SEL_BINDING, 8'h01, 32'h0, 32'h0020_0003}};
    logic mclk = 1'h0, resetn = 1'h0, en = 1'h0;
    logic [3:0] be = 4'h0, hl = 4'h7, dsf, scf;
    logic [15:0] elem;
    logic [31:0] rdata, got;
    cop_req_s cop_req = '0;
    ctx_pipe_s [3:0] pipe = '0;
    int fails = 0, tests_run = 0, cyc = 0;
    ctx_regs #(.NUM_CTX(4), .ELEM_PRESET(16'h1230)) DUT (.mclk(mclk),
        .resetn(resetn), .cop_req(cop_req), .binding_config_enable(en),
        .bus_err_ctx(be), .halted(hl), .pipe(pipe), .rdata(rdata),
        .rvalid(), .delay_slot_stop_flag(dsf), .sc_fail(scf),
        .owning_element_field(elem));
    always #2 mclk = ~mclk;
    task automatic conclude;
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic xfer(input cop_req_s r);
        cop_req <= r;
        @(posedge mclk);
        cop_req <= '0;
        @(negedge mclk);
        got = rdata;
        @(posedge mclk);
    endtask : xfer
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            conclude;
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'h1;
        repeat (2) @(posedge mclk);
        `CHK("elem", 16'h1230, elem)
        foreach (ROWS[i]) begin
            en <= ROWS[i].en;
            if (ROWS[i].w) xfer({2'h1, ROWS[i].s, ROWS[i].c, ROWS[i].d});
            xfer({2'h2, ROWS[i].s, ROWS[i].c, 32'h0});
            `CHK("row", ROWS[i].e, got)
        end
        be <= 4'h5;
        @(posedge mclk);
        be <= 4'h0;
        xfer({2'h2, SEL_BINDING, 8'h0, 32'h0});
        `CHK("berr", 32'h0002_0000, got)
        xfer({2'h2, SEL_BINDING, 8'h2, 32'h0});
        `CHK("berr2", 32'h0042_0009, got)
        pipe[0].ll_exec <= 1'h1;
        @(posedge mclk);
        pipe[0].ll_exec <= 1'h0;
        cop_req <= {2'h1, SEL_RESUME, 8'h0, 32'h100};
        @(posedge mclk);
        cop_req <= '0;
        pipe[0].sc_exec <= 1'h1;
        @(posedge mclk);
        pipe[0].sc_exec <= 1'h0;
        @(negedge mclk);
        `CHK("scfail", 1'h1, scf[0])
        @(posedge mclk);
        pipe[3].retire_pc <= 32'h300;
        pipe[3].retire <= 1'h1;
        @(posedge mclk);
        pipe[3].retire_pc <= 32'h304;
        pipe[3].in_delay_slot <= 1'h1;
        pipe[3].branch_pc <= 32'h400;
        @(posedge mclk);
        pipe[3].retire <= 1'h0;
        xfer({2'h2, SEL_RESUME, 8'h3, 32'h0});
        `CHK("running", 32'h300, got)
        pipe[3].halt_req <= 1'h1;
        hl[3] <= 1'h1;
        repeat (2) @(posedge mclk);
        xfer({2'h2, SEL_RESUME, 8'h3, 32'h0});
        `CHK("dsf", 1'h1, dsf[3])
        `CHK("restart", 32'h400, got)
        xfer({2'h1, SEL_RESUME, 8'h3, 32'h800});
        `CHK("dsclr", 1'h0, dsf[3])
        conclude;
    end
endmodule : ctx_regs_test
`default_nettype wire
